// >>> sim/dup_host_model.sv
// Host CPU model driving the parallel bus pins
`timescale 1ns/100ps
module dup_host_model
  import dup_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_n_in,
  output dup_host_s       host_out
);
  initial host_out = '1;
  task automatic access(input logic cs, ch, wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_in);
    host_out = '{cs, ch, a, d, !wr, wr};
    for (int n = 0; n < 6; n++) begin
      @(posedge core_clk_in);
      if (!wr && !data_oe_n_in) break;
    end
    q = data_in;
    @(negedge core_clk_in);
    host_out.write_strobe_n = 1'b1;
    host_out.read_strobe_n = 1'b1;
    repeat (3) @(negedge core_clk_in);
    host_out.cs_n = 1'b1;
    host_out.data = ~host_out.data;
  endtask
endmodule // dup_host_model

// >>> sim/dup_pin_ctrl_properties.sv
// Assertion checker for the dual UART pin-level block
`timescale 1ns/100ps
module dup_pin_ctrl_properties
  import dup_pkg::*;
(
  input wire logic                        core_clk_in,
  input wire logic                        rst_b_in,
  input wire dup_host_s                   host_in,
  input wire logic [7:0]                  wr_data_out,
  input wire logic [NUM_CH-1:0]           thr_load_out,
  input wire logic                        data_oe_n_out,
  input wire dup_chan_stat_s [NUM_CH-1:0] chan_stat_in,
  input wire logic [NUM_CH-1:0]           tx_pin_out,
  input wire logic [NUM_CH-1:0]           dtr_n_out,
  input wire logic [NUM_CH-1:0]           rts_n_out,
  input wire logic                        multi_function_out_a_out,
  input wire logic                        multi_function_out_b_out,
  input wire logic                        transmit_ready_n_a_out,
  input wire logic                        transmit_ready_n_b_out,
  input wire logic                        irq_out_a_out,
  input wire logic                        irq_oe_n_a_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_rd_idle;
    host_in.read_strobe_n [*3];
  endsequence
  sequence s_wr_seen;
    !$past(host_in.write_strobe_n, 2) && $past(host_in.addr, 2) == ADDR_HOLD;
  endsequence
  property p_reset_state;
    $rose(rst_b_in) |-> tx_pin_out == 2'h3 && dtr_n_out == 2'h3 &&
      rts_n_out == 2'h3 && multi_function_out_a_out &&
      multi_function_out_b_out && !irq_out_a_out;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not at reset levels");
  property p_dtr;
    $changed(dtr_n_out[CH_A]) |-> dtr_n_out[CH_A] == !wr_data_out[MCR_DTR];
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready level mismatch");
  property p_rts;
    $changed(rts_n_out[CH_B]) |-> rts_n_out[CH_B] == !wr_data_out[MCR_RTS];
  endproperty
  a_rts: assert property (p_rts)
    else $error("request to send level mismatch");
  property p_txrdy_a;
    rst_b_in |=> transmit_ready_n_a_out == $past(chan_stat_in[CH_A].tx_full);
  endproperty
  a_txrdy_a: assert property (p_txrdy_a)
    else $error("transmit ready A mismatch");
  property p_txrdy_b;
    rst_b_in |=> transmit_ready_n_b_out == $past(chan_stat_in[CH_B].tx_full);
  endproperty
  a_txrdy_b: assert property (p_txrdy_b)
    else $error("transmit ready B mismatch");
  property p_irq_a;
    irq_out_a_out |-> !irq_oe_n_a_out;
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("interrupt high while pin disabled");
  property p_rd_idle;
    s_rd_idle |-> data_oe_n_out;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("data bus driven without read");
  property p_rd_fall;
    $fell(data_oe_n_out) |-> $past(host_in.read_strobe_n, 2) == 1'b0 &&
      $past(host_in.cs_n, 2) == 1'b0;
  endproperty
  a_rd_fall: assert property (p_rd_fall)
    else $error("data bus driven without selected read");
  property p_thr_load;
    |thr_load_out |-> s_wr_seen ##1 thr_load_out == 2'h0;
  endproperty
  a_thr_load: assert property (p_thr_load)
    else $error("holding load without write strobe");
  property p_tx_idle;
    !chan_stat_in[CH_A].tx_enable |=> tx_pin_out[CH_A];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("serial out low while disabled");
endmodule // dup_pin_ctrl_properties

bind dup_pin_ctrl dup_pin_ctrl_properties dup_pin_ctrl_properties_inst (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .host_in(host_in),
  .wr_data_out(wr_data_out), .thr_load_out(thr_load_out),
  .data_oe_n_out(data_oe_n_out), .chan_stat_in(chan_stat_in),
  .tx_pin_out(tx_pin_out), .dtr_n_out(dtr_n_out), .rts_n_out(rts_n_out),
  .multi_function_out_a_out(multi_function_out_a_out),
  .multi_function_out_b_out(multi_function_out_b_out),
  .transmit_ready_n_a_out(transmit_ready_n_a_out),
  .transmit_ready_n_b_out(transmit_ready_n_b_out),
  .irq_out_a_out(irq_out_a_out), .irq_oe_n_a_out(irq_oe_n_a_out));

// >>> sim/test_dual_uart_pin_level_control.sv
// Self-checking bench for the dual UART pin-level block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_dual_uart_pin_level_control;
  import dup_pkg::*;
  logic                        core_clk_in, rst_b_in;
  dup_host_s                   host_in;
  dup_modem_s [NUM_CH-1:0]     modem_n_in;
  dup_chan_stat_s [NUM_CH-1:0] st;
  logic [NUM_CH-1:0]           rx_pin_in, tx_pin_out, rxr, dtr_n_out;
  logic [NUM_CH-1:0]           rts_n_out;
  logic [7:0]                  data_out, q;
  logic                        oe_n, mf_a, mf_b, tra, trb, irqa, ioa, iob;
  logic                        irqb, exp_mf;
  logic [NUM_CH-1:0]           transmit_holding_reg, receive_holding_reg;
  logic [7:0]                  wd;
  int                          mismatches, n_tests, cyc, n_thr, n_rhr;

  dup_pin_ctrl dup_pin_ctrl_inst (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .host_in(host_in),
    .data_out(data_out), .data_oe_n_out(oe_n), .wr_data_out(wd),
    .thr_load_out(transmit_holding_reg), .rhr_unload_out(receive_holding_reg), .modem_n_in(modem_n_in),
    .rx_pin_in(rx_pin_in), .chan_stat_in(st), .tx_pin_out(tx_pin_out),
    .rx_to_receiver_out(rxr), .dtr_n_out(dtr_n_out), .rts_n_out(rts_n_out),
    .multi_function_out_a_out(mf_a), .multi_function_out_b_out(mf_b),
    .transmit_ready_n_a_out(tra), .transmit_ready_n_b_out(trb),
    .irq_out_a_out(irqa), .irq_out_b_out(irqb), .irq_oe_n_a_out(ioa),
    .irq_oe_n_b_out(iob));
  dup_host_model dup_host_model_inst (.core_clk_in(core_clk_in),
    .data_in(data_out), .data_oe_n_in(oe_n), .host_out(host_in));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (transmit_holding_reg[CH_A]) n_thr++;
    if (receive_holding_reg[CH_A]) n_rhr++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    dup_host_model_inst.access(1'b0, ch, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] e);
    dup_host_model_inst.access(1'b0, ch, 1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask

  initial begin
    rst_b_in = 1'b0;
    modem_n_in = '1;
    rx_pin_in = '1;
    st = '0;
    repeat (3) @(negedge core_clk_in);
    `CHK({tx_pin_out, rxr, dtr_n_out, rts_n_out}, 8'hFF)
    `CHK({mf_a, mf_b, oe_n, ioa, iob, tra, trb, irqa, irqb}, 9'h1FC)
    rst_b_in = 1'b1;
    settle(2);
    `CHK({tra, trb}, 2'h0)
    st[CH_A].tx_full = 1'b1;
    settle(2);
    `CHK({tra, trb}, 2'h2)
    st[CH_A].tx_full = 1'b0;
    wr(1'b1, ADDR_MCR, 8'h03);
    dup_host_model_inst.access(1'b1, 1'b0, 1'b1, ADDR_SPR, 8'h3C, q);
    wr(1'b0, ADDR_MCR, 8'h02);
    `CHK({dtr_n_out, rts_n_out}, 4'h8)
    wr(1'b1, ADDR_MCR, 8'h00);
    wr(1'b0, ADDR_MCR, 8'h00);
    `CHK({dtr_n_out, rts_n_out}, 4'hF)
    wr(1'b1, ADDR_SPR, 8'hA5);
    rd(1'b1, ADDR_SPR, 8'hA5);
    rd(1'b0, ADDR_SPR, 8'h00);
    rd(1'b1, ADDR_LSR, 8'h00);
    wr(1'b1, ADDR_LCR, 8'h80);
    wr(1'b1, ADDR_FCR_AFR, 8'h01);
    wr(1'b1, ADDR_LCR, 8'h00);
    wr(1'b1, ADDR_SPR, 8'h3C);
    rd(1'b0, ADDR_SPR, 8'h3C);
    wr(1'b1, ADDR_LCR, 8'h80);
    wr(1'b1, ADDR_FCR_AFR, 8'h00);
    wr(1'b1, ADDR_LCR, 8'h00);
    wr(1'b0, ADDR_LCR, 8'h00);
    wr(1'b1, ADDR_SPR, 8'h55);
    rd(1'b0, ADDR_SPR, 8'h3C);
    wr(1'b1, ADDR_HOLD, 8'h5A);
    `CHK(n_thr, 1)
    `CHK(wd, 8'h5A)
    rd(1'b1, ADDR_HOLD, 8'h00);
    `CHK(n_rhr, 1)
    modem_n_in[CH_A] = 4'h0;
    settle(4);
    rd(1'b1, ADDR_MSR, 8'hFB);
    rd(1'b1, ADDR_MSR, 8'hF0);
    modem_n_in[CH_A].ri_n = 1'b1;
    settle(4);
    rd(1'b1, ADDR_MSR, 8'hB4);
    modem_n_in[CH_B].cts_n = 1'b0;
    settle(4);
    rd(1'b0, ADDR_MSR, 8'h11);
    st[CH_A].rx_data_irq = 1'b1;
    wr(1'b1, ADDR_IER, 8'h01);
    wr(1'b1, ADDR_MCR, 8'h08);
    `CHK({irqa, ioa}, 2'h2)
    wr(1'b1, ADDR_IER, 8'h00);
    `CHK({irqa, ioa}, 2'h0)
    wr(1'b1, ADDR_MCR, 8'h00);
    `CHK({irqa, ioa}, 2'h1)
    for (int c = 0; c < 5; c++) begin
      wr(1'b1, ADDR_LCR, 8'h80);
      wr(1'b1, ADDR_FCR_AFR, 8'((c == 4 ? 2 : c) << AFR_SEL_LO));
      wr(1'b1, ADDR_LCR, 8'h00);
      if (c == 4) wr(1'b1, ADDR_FCR_AFR, 8'h09);
      for (int k = 0; k < 2; k++) begin
        wr(1'b1, ADDR_MCR, 8'(k << MCR_IRQ_EN));
        st[CH_A].baud_x16 = k[0];
        st[CH_A].rx_empty = k[0];
        settle(3);
        exp_mf = (c == 4) | (c == 1 || c == 2 ? k[0] : !k[0]);
        `CHK({mf_a, mf_b}, {exp_mf, 1'b1})
      end
    end
    st[CH_A].rx_empty = 1'b0;
    st[CH_A].rx_trig_hit = 1'b1;
    settle(3);
    `CHK(mf_a, 1'b0)
    rx_pin_in = 2'h2;
    settle(4);
    `CHK({tx_pin_out[CH_A], rxr[CH_A]}, 2'h2)
    st[CH_A].tx_enable = 1'b1;
    settle(2);
    `CHK(tx_pin_out[CH_A], 1'b0)
    wr(1'b1, ADDR_MCR, 8'h10);
    rx_pin_in = 2'h3;
    settle(4);
    `CHK({tx_pin_out[CH_A], rxr[CH_A]}, 2'h2)
    rst_b_in = 1'b0;
    settle(1);
    `CHK({mf_a, tx_pin_out, rxr, oe_n}, 6'h3F)
    rst_b_in = 1'b1;
    settle(2);
    end_sim();
  end
endmodule // test_dual_uart_pin_level_control

// >>> verilog/dup_pin_ctrl.sv
// Pin-level control of both channels of the dual UART
// Notes on behaviour
// - Write strobe fall loads addressed register
// - Alternate function bits 1-2 pick pin function
// - Indicator high when interrupt pin disabled
// - MF pin high after reset
// - Baud mode shows 16x baud clock
// - Receive-ready low when characters available, in DMA mode 1 only once trigger hit
// - Receive-ready high when empty, or below trigger in DMA mode 1
// - Reset clears registers, sets serial paths, MF, transmit-ready, DTR and RTS outputs high
// - Transmit-ready low while space remains
// - Ready outputs serve DMA modes 0, 1
// - CTS state readable in status bit 4
// - Modem control bit 0 drives DTR low
// - Modem control bit 1 drives RTS low
// - RI rising edge raises modem interrupt
// - TX pin idles high
// - Loop-back routes TX into receiver
// - CD, DSR, CTS inputs active low
// - Chip select and channel select pick channel
// - Interrupt needs control bit 3, enable, condition
// - Read strobe fall drives addressed register
`timescale 1ns/100ps
module dup_pin_ctrl
  import dup_pkg::*;
(
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire dup_host_s                   host_in,
  output logic      [7:0]                  data_out,
  output logic                             data_oe_n_out,
  output logic      [7:0]                  wr_data_out,
  output logic      [NUM_CH-1:0]           thr_load_out,
  output logic      [NUM_CH-1:0]           rhr_unload_out,
  input  wire dup_modem_s [NUM_CH-1:0]     modem_n_in,
  input  wire logic [NUM_CH-1:0]           rx_pin_in,
  input  wire dup_chan_stat_s [NUM_CH-1:0] chan_stat_in,
  output logic      [NUM_CH-1:0]           tx_pin_out,
  output logic      [NUM_CH-1:0]           rx_to_receiver_out,
  output logic      [NUM_CH-1:0]           dtr_n_out,
  output logic      [NUM_CH-1:0]           rts_n_out,
  output logic                             multi_function_out_a_out,
  output logic                             multi_function_out_b_out,
  output logic                             transmit_ready_n_a_out,
  output logic                             transmit_ready_n_b_out,
  output logic                             irq_out_a_out,
  output logic                             irq_out_b_out,
  output logic                             irq_oe_n_a_out,
  output logic                             irq_oe_n_b_out
);

  localparam int unsigned HOST_W  = $bits(dup_host_s);
  localparam int unsigned MODEM_W = NUM_CH * $bits(dup_modem_s);
  localparam logic [HOST_W-1:0] HOST_IDLE = {1'b1, 1'b0, 3'h0, 8'h00,
                                             1'b1, 1'b1};

  // Pin synchronisers
  dup_host_s                 host_s;
  dup_modem_s [NUM_CH-1:0]   modem_s;
  logic       [NUM_CH-1:0]   rx_pin_s;

  dup_sync #(.WIDTH(HOST_W), .RST_VAL(HOST_IDLE)) u_sync_host (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        (host_in),
    .q_out       (host_s)
  );

  dup_sync #(.WIDTH(MODEM_W), .RST_VAL({NUM_CH{MODEM_N_RST}})) u_sync_modem (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        (modem_n_in),
    .q_out       (modem_s)
  );

  dup_sync #(.WIDTH(NUM_CH), .RST_VAL({NUM_CH{1'b1}})) u_sync_rx (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        (rx_pin_in),
    .q_out       (rx_pin_s)
  );

  // Strobe edge detection
  logic wr_n_prev_q;
  logic rd_n_prev_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_n_prev_q <= 1'b1;
      rd_n_prev_q <= 1'b1;
    end else begin
      wr_n_prev_q <= host_s.write_strobe_n;
      rd_n_prev_q <= host_s.read_strobe_n;
    end
  end

  wire logic wr_fall = wr_n_prev_q & ~host_s.write_strobe_n;
  wire logic rd_fall = rd_n_prev_q & ~host_s.read_strobe_n;
  wire logic cs_act  = ~host_s.cs_n;

  // Per-channel views gathered for shared logic
  logic [NUM_CH-1:0]       conc_wr;
  logic [NUM_CH-1:0]       ch_hit;
  logic [NUM_CH-1:0][7:0]  rd_val;
  logic [NUM_CH-1:0]       mf_pin;
  logic [NUM_CH-1:0]       txrdy_n;
  logic [NUM_CH-1:0]       irq_pin;
  logic [NUM_CH-1:0]       irq_oe_n;

  wire logic conc_any = |conc_wr;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [7:0] ier_q;
      logic [7:0] fcr_q;
      logic [7:0] lcr_q;
      logic [7:0] mcr_q;
      logic [7:0] spr_q;
      logic [7:0] afr_q;
      logic [3:0] delta_q;
      logic [3:0] delta_d;
      dup_modem_s modem_prev_q;
      logic       mf_q;
      logic       txrdy_n_q;
      logic       irq_q;
      logic       tx_q;
      logic       rxi_q;
      logic       dtr_n_q;
      logic       rts_n_q;

      assign ch_hit[ch] = cs_act & (host_s.channel_select == (ch == CH_A));
      assign conc_wr[ch] = afr_q[AFR_CONC];

      wire logic dlab   = lcr_q[LCR_DLAB];
      wire logic addr_w = ch_hit[ch] | (cs_act & conc_any);
      wire logic wr_ch  = wr_fall & addr_w;
      wire logic rd_ch  = rd_fall & ch_hit[ch];
      wire logic [2:0] a = host_s.addr;
      wire logic wr_ier = wr_ch & ~dlab & (a == ADDR_IER);
      wire logic wr_fcr = wr_ch & ~dlab & (a == ADDR_FCR_AFR);
      wire logic wr_afr = wr_ch &  dlab & (a == ADDR_FCR_AFR);
      wire logic wr_lcr = wr_ch & (a == ADDR_LCR);
      wire logic wr_mcr = wr_ch & ~dlab & (a == ADDR_MCR);
      wire logic wr_spr = wr_ch & ~dlab & (a == ADDR_SPR);
      wire logic rd_msr = rd_ch & ~dlab & (a == ADDR_MSR);

      assign thr_load_out[ch]   = wr_ch & ~dlab & (a == ADDR_HOLD);
      assign rhr_unload_out[ch] = rd_ch & ~dlab & (a == ADDR_HOLD);

      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ier_q <= REG_RST;
          fcr_q <= REG_RST;
          lcr_q <= REG_RST;
          mcr_q <= REG_RST;
          spr_q <= REG_RST;
          afr_q <= REG_RST;
        end else begin
          if (wr_ier) ier_q <= host_s.data;
          if (wr_fcr) fcr_q <= host_s.data;
          if (wr_afr) afr_q <= host_s.data;
          if (wr_lcr) lcr_q <= host_s.data;
          if (wr_mcr) mcr_q <= host_s.data;
          if (wr_spr) spr_q <= host_s.data;
        end
      end

      // active-low modem inputs turned into asserted levels
      wire dup_modem_s mdm = modem_s[ch];
      wire logic [3:0] msr_hi = {~mdm.cd_n, ~mdm.ri_n, ~mdm.dsr_n,
                                 ~mdm.cts_n};
      // ring trailing edge and other deltas
      wire logic [3:0] delta_set = {
        mdm.cd_n  ^ modem_prev_q.cd_n,
        mdm.ri_n  & ~modem_prev_q.ri_n,
        mdm.dsr_n ^ modem_prev_q.dsr_n,
        mdm.cts_n ^ modem_prev_q.cts_n};
      // Set wins over the clear on status read
      assign delta_d = (delta_q & {4{~rd_msr}}) | delta_set;

      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          delta_q      <= DELTA_RST;
          modem_prev_q <= MODEM_N_RST;
        end else begin
          delta_q      <= delta_d;
          modem_prev_q <= mdm;
        end
      end

      // read value; cts lands in bit 4
      wire logic [7:0] msr_val = {msr_hi, delta_q};
      assign rd_val[ch] = (dlab && a == ADDR_FCR_AFR) ? afr_q :
                          (!dlab && a == ADDR_MSR)    ? msr_val :
                          (!dlab && a == ADDR_MCR)    ? mcr_q :
                          (!dlab && a == ADDR_SPR)    ? spr_q :
                          (a == ADDR_LCR)             ? lcr_q : REG_RST;

      wire logic [3:0] irq_src = {|delta_q, chan_stat_in[ch].line_err,
                                  chan_stat_in[ch].thr_empty,
                                  chan_stat_in[ch].rx_data_irq};
      wire logic [3:0] irq_en  = {ier_q[IER_MODEM], ier_q[IER_LINE],
                                  ier_q[IER_THR_EMP], ier_q[IER_RX_DATA]};
      wire logic irq_d = |(irq_src & irq_en);
      assign irq_oe_n[ch] = ~mcr_q[MCR_IRQ_EN];

      // receive-ready waits for trigger in DMA mode 1
      wire logic dma1   = fcr_q[FCR_FIFO_EN] & fcr_q[FCR_DMA_MODE];
      wire logic rx_rdy = ~chan_stat_in[ch].rx_empty &
                          (~dma1 | chan_stat_in[ch].rx_trig_hit);

      dup_mf_sel_e mf_sel;
      assign mf_sel = dup_mf_sel_e'(afr_q[AFR_SEL_LO +: 2]);
      logic mf_d;
      always_comb begin
        case (mf_sel)
          MF_BAUD:   mf_d = chan_stat_in[ch].baud_x16;
          MF_RX_RDY: mf_d = ~rx_rdy;
          MF_IRQ_IND: mf_d = ~mcr_q[MCR_IRQ_EN];
          default:    mf_d = ~mcr_q[MCR_IRQ_EN];
        endcase
      end

      wire logic loop   = mcr_q[MCR_LOOP];
      wire logic tx_bit = chan_stat_in[ch].tx_enable ?
                          chan_stat_in[ch].tx_serial : 1'b1;

      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          mf_q      <= 1'b1;
          txrdy_n_q <= 1'b1;
          irq_q     <= 1'b0;
          tx_q      <= 1'b1;
          rxi_q     <= 1'b1;
          dtr_n_q   <= 1'b1;
          rts_n_q   <= 1'b1;
        end else begin
          mf_q      <= mf_d;
          txrdy_n_q <= chan_stat_in[ch].tx_full;
          irq_q     <= irq_d;
          // idle high, held high in loop-back
          tx_q      <= loop ? 1'b1 : tx_bit;
          rxi_q     <= loop ? tx_bit : rx_pin_s[ch];
          dtr_n_q   <= ~mcr_q[MCR_DTR];
          rts_n_q   <= ~mcr_q[MCR_RTS];
        end
      end

      assign mf_pin[ch]             = mf_q;
      assign txrdy_n[ch]            = txrdy_n_q;
      assign irq_pin[ch]            = irq_q & mcr_q[MCR_IRQ_EN];
      assign tx_pin_out[ch]         = tx_q;
      assign rx_to_receiver_out[ch] = rxi_q;
      assign dtr_n_out[ch]          = dtr_n_q;
      assign rts_n_out[ch]          = rts_n_q;
    end
  endgenerate

  // read data captured on strobe fall
  logic [7:0] data_q;
  logic [7:0] wr_data_q;
  wire logic [7:0] rd_sel = ch_hit[CH_A] ? rd_val[CH_A] : rd_val[CH_B];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_q    <= REG_RST;
      wr_data_q <= REG_RST;
    end else begin
      if (rd_fall && cs_act) data_q <= rd_sel;
      if (wr_fall && cs_act) wr_data_q <= host_s.data;
    end
  end

  // bus driven while selected and read strobe low, from the cycle after its fall
  assign data_out      = data_q;
  assign data_oe_n_out = ~(cs_act & ~host_s.read_strobe_n & ~rd_fall);
  assign wr_data_out   = wr_data_q;

  assign multi_function_out_a_out = mf_pin[CH_A];
  assign multi_function_out_b_out = mf_pin[CH_B];
  assign transmit_ready_n_a_out   = txrdy_n[CH_A];
  assign transmit_ready_n_b_out   = txrdy_n[CH_B];
  assign irq_out_a_out            = irq_pin[CH_A];
  assign irq_out_b_out            = irq_pin[CH_B];
  assign irq_oe_n_a_out           = irq_oe_n[CH_A];
  assign irq_oe_n_b_out           = irq_oe_n[CH_B];

endmodule // dup_pin_ctrl

// >>> verilog/dup_pkg.sv
// Shared constants and carrier types for the dual UART pin-level block
package dup_pkg;

  localparam int unsigned NUM_CH       = 2;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned CH_A         = 0;
  localparam int unsigned CH_B         = 1;

  // Register offsets on the three address inputs
  localparam logic [2:0] ADDR_HOLD     = 3'h0;
  localparam logic [2:0] ADDR_IER      = 3'h1;
  localparam logic [2:0] ADDR_FCR_AFR  = 3'h2;
  localparam logic [2:0] ADDR_LCR      = 3'h3;
  localparam logic [2:0] ADDR_MCR      = 3'h4;
  localparam logic [2:0] ADDR_LSR      = 3'h5;
  localparam logic [2:0] ADDR_MSR      = 3'h6;
  localparam logic [2:0] ADDR_SPR      = 3'h7;

  // Field positions
  localparam int unsigned MCR_DTR      = 0;
  localparam int unsigned MCR_RTS      = 1;
  localparam int unsigned MCR_IRQ_EN   = 3;
  localparam int unsigned MCR_LOOP     = 4;
  localparam int unsigned LCR_DLAB     = 7;
  localparam int unsigned AFR_CONC     = 0;
  localparam int unsigned AFR_SEL_LO   = 1;
  localparam int unsigned FCR_FIFO_EN  = 0;
  localparam int unsigned FCR_DMA_MODE = 3;
  localparam int unsigned IER_RX_DATA  = 0;
  localparam int unsigned IER_THR_EMP  = 1;
  localparam int unsigned IER_LINE     = 2;
  localparam int unsigned IER_MODEM    = 3;
  localparam int unsigned MSR_DCTS     = 0;
  localparam int unsigned MSR_DDSR     = 1;
  localparam int unsigned MSR_TERI     = 2;
  localparam int unsigned MSR_DDCD     = 3;
  localparam int unsigned MSR_CTS      = 4;
  localparam int unsigned MSR_DSR      = 5;
  localparam int unsigned MSR_RI       = 6;
  localparam int unsigned MSR_CD       = 7;

  // Values after reset
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [3:0] DELTA_RST     = 4'h0;
  localparam logic [3:0] MODEM_N_RST   = 4'hF;

  typedef enum logic [1:0] {
    MF_IRQ_IND = 2'h0,
    MF_BAUD    = 2'h1,
    MF_RX_RDY  = 2'h2,
    MF_SPARE   = 2'h3
  } dup_mf_sel_e;

  // Host parallel-bus pins
  typedef struct packed {
    logic       cs_n;
    logic       channel_select;
    logic [2:0] addr;
    logic [7:0] data;
    logic       write_strobe_n;
    logic       read_strobe_n;
  } dup_host_s;

  // Active-low modem status pins of one channel
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } dup_modem_s;

  // Status from the channel's FIFOs, transmitter and baud generator
  typedef struct packed {
    logic rx_empty;
    logic rx_trig_hit;
    logic tx_full;
    logic tx_serial;
    logic tx_enable;
    logic line_err;
    logic thr_empty;
    logic rx_data_irq;
    logic baud_x16;
  } dup_chan_stat_s;

endpackage

// >>> verilog/dup_sync.sv
// Two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/100ps
module dup_sync #(
  parameter int unsigned        WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule // dup_sync
